// *** rww_mcu_model.sv ***
`timescale 1ns/1ps
// Microcontroller side of the trigger pin; quiet while held in reset
module rww_mcu_model #(
  parameter int LEVEL_CYC = 9
) (
  input wire logic core_clk, // Core clock
  input wire logic reset_out_n, // Reset from the supervisor
  input wire logic fire, // Request one trigger pulse
  output logic trigger_in // Trigger pin
);
  int cnt_q = 0;
  initial trigger_in = 1'b0;
  // One pulse per request: high, then low, each level spanning at least two samples at the testbench's fast timing
  always @(posedge core_clk) begin
    if (reset_out_n !== 1'b1) begin
      cnt_q <= 0;
      trigger_in <= 1'b0;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
      trigger_in <= (cnt_q > LEVEL_CYC);
    end else if (fire) begin
      cnt_q <= 2 * LEVEL_CYC;
      trigger_in <= 1'b1;
    end
  end
endmodule

// *** rww_pkg.sv ***
package rww_pkg;
  // Core clock rate
  localparam int CLK_HZ = 20000000;
  // Trigger sample period with fast timing, in microseconds
  localparam int SAMPLE_TIME_US = 250;
  // Cycles per sample tick with fast timing
  localparam int SAMPLE_CYC_DEF = SAMPLE_TIME_US * (CLK_HZ / 1000000);
  // Slow timing stretches every tick-counted duration by this factor
  localparam int SLOW_FACTOR = 4;
  // Power-up reset delay, in milliseconds
  localparam int POR_DELAY_MS = 8;
  // Ignore, open and closed window length, in milliseconds
  localparam int WINDOW_MS = 32;
  // Durations in sample ticks
  localparam int POR_TICKS_DEF = POR_DELAY_MS * 1000 / SAMPLE_TIME_US;
  localparam int WIN_TICKS_DEF = WINDOW_MS * 1000 / SAMPLE_TIME_US;
  // Supply dropout filter, in nanoseconds, rounded up to cycles
  localparam int REACT_TIME_NS = 10000;
  localparam int REACT_CYC_DEF = (REACT_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // Sample history oldest first: high, high, low, low
  localparam logic [3:0] TRIG_PATTERN = 4'hc;
  // Supply comparator indices
  localparam int SUP_CORE = 0;
  localparam int SUP_IO = 1;
  // Synchroniser lanes
  localparam int SY_CORE = 0;
  localparam int SY_IO = 1;
  localparam int SY_TRIG = 2;
  localparam int SY_OFF = 3;
  localparam int SY_SLOW = 4;
  localparam int SY_N = 5;

  // Supervisor states, one-hot
  typedef enum logic [6:0] {
    ST_WAIT_CORE = 7'h01,
    ST_DELAY = 7'h02,
    ST_WAIT_IO = 7'h04,
    ST_IGNORE = 7'h08,
    ST_OPEN = 7'h10,
    ST_CLOSED = 7'h20,
    ST_WD_OFF = 7'h40
  } rww_state_type;
endpackage

// *** rww_supervisor.sv ***
`timescale 1ns/1ps
module rww_supervisor
  import rww_pkg::*;
#(
  parameter int SAMPLE_CYC = SAMPLE_CYC_DEF,
  parameter int POR_TICKS = POR_TICKS_DEF,
  parameter int WIN_TICKS = WIN_TICKS_DEF,
  parameter int REACT_CYC = REACT_CYC_DEF
) (
  input wire logic core_clk, // 20 MHz core clock
  input wire logic reset, // Async reset, active high
  input wire logic core_supply_good, // Core supply comparator, high when above core_threshold
  input wire logic io_supply_good, // I/O supply comparator, high when above io_threshold
  input wire logic trigger_in, // Watchdog trigger pin from the microcontroller
  input wire logic strap_low, // Timing strap held low: watchdog off
  input wire logic strap_at_core, // Timing strap tied to core supply: slow timing
  output logic reset_out_n, // Microcontroller reset, low active
  output logic wd_fault_early, // One-cycle pulse on premature trigger
  output logic wd_fault_late // One-cycle pulse on missing trigger
);
  if (POR_TICKS < 1 || POR_TICKS > 255 || WIN_TICKS < 1 || WIN_TICKS > 255) begin : g_bad_ticks
    $error("rww_supervisor: tick counts must be 1 to 255");
  end
  if (REACT_CYC < 1 || REACT_CYC > 255) begin : g_bad_react
    $error("rww_supervisor: REACT_CYC must be 1 to 255");
  end

  localparam logic [7:0] POR_LAST = 8'(POR_TICKS - 1);
  localparam logic [7:0] WIN_LAST = 8'(WIN_TICKS - 1);
  localparam logic [7:0] REACT_LAST = 8'(REACT_CYC - 1);

  rww_state_type state_q;
  rww_state_type state_d;
  logic [SY_N-1:0] sync1_q;
  logic [SY_N-1:0] sync2_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [1:0] sup_fail_q;
  logic [7:0] low_cnt_q [2];
  logic reset_out_n_q;
  logic early_q;
  logic late_q;

  rww_tb_if tb_if ();

  // Released states drive reset high
  function automatic logic is_released(input rww_state_type s);
    return s == ST_IGNORE || s == ST_OPEN || s == ST_CLOSED || s == ST_WD_OFF;
  endfunction

  // Two-stage synchronisers for all pins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {strap_at_core, strap_low, trigger_in, io_supply_good, core_supply_good};
      sync2_q <= sync1_q;
    end
  end

  wire core_s = sync2_q[SY_CORE];
  wire io_s = sync2_q[SY_IO];
  wire wd_off_s = sync2_q[SY_OFF];
  wire [1:0] sup_good_s = {io_s, core_s};

  // Sampler sees the synchronised trigger and strap
  assign tb_if.trig_lvl = sync2_q[SY_TRIG];
  assign tb_if.slow = sync2_q[SY_SLOW];

  rww_timebase #(
    .SAMPLE_CYC(SAMPLE_CYC)
  ) u_timebase (
    .core_clk(core_clk),
    .reset(reset),
    .tb(tb_if.src)
  );

  wire tick = tb_if.tick;
  wire trig_valid = tb_if.trig_valid;

  // Dropout filters, a supply fails only after REACT_CYC bad cycles
  for (genvar k = 0; k < 2; k++) begin : g_filt
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        low_cnt_q[k] <= 8'h00;
        sup_fail_q[k] <= 1'b0;
      end else if (sup_good_s[k]) begin
        low_cnt_q[k] <= 8'h00;
        sup_fail_q[k] <= 1'b0;
      end else if (low_cnt_q[k] == REACT_LAST) begin
        sup_fail_q[k] <= 1'b1;
      end else begin
        low_cnt_q[k] <= low_cnt_q[k] + 8'h01;
      end
    end
  end

  // Window and delay decode
  wire any_fail = |sup_fail_q;
  wire core_fail = sup_fail_q[SUP_CORE];
  wire [7:0] last_tick = (state_q == ST_DELAY) ? POR_LAST : WIN_LAST;
  wire expire = tick && cnt_q == last_tick;
  wire wd_active = state_q == ST_IGNORE || state_q == ST_OPEN || state_q == ST_CLOSED;
  wire fault_early = state_q == ST_CLOSED && trig_valid && !expire && !any_fail && !wd_off_s;
  wire fault_late = state_q == ST_OPEN && expire && !trig_valid && !any_fail && !wd_off_s;

  // Next state of the supervisor
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_WAIT_CORE: begin
        if (core_s && !core_fail) begin
          state_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (core_fail) begin
          state_d = ST_WAIT_CORE;
        end else if (expire) begin
          state_d = ST_WAIT_IO;
        end
      end
      ST_WAIT_IO: begin
        if (core_fail) begin
          state_d = ST_WAIT_CORE;
        end else if (io_s) begin
          state_d = wd_off_s ? ST_WD_OFF : ST_IGNORE;
        end
      end
      ST_IGNORE: begin
        if (expire) begin
          state_d = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (trig_valid) begin
          state_d = ST_CLOSED;
        end else if (expire) begin
          state_d = ST_DELAY;
        end
      end
      ST_CLOSED: begin
        if (expire) begin
          state_d = trig_valid ? ST_CLOSED : ST_OPEN;
        end else if (trig_valid) begin
          state_d = ST_DELAY;
        end
      end
      ST_WD_OFF: begin
        if (!wd_off_s) begin
          state_d = ST_IGNORE;
        end
      end
      default: begin
        state_d = ST_WAIT_CORE;
      end
    endcase
    if (wd_active && wd_off_s) begin
      state_d = ST_WD_OFF;
    end
    if (is_released(state_q) && any_fail) begin
      state_d = ST_WAIT_CORE;
    end
  end

  // Tick counter restarts on every state change
  always_comb begin
    cnt_d = cnt_q;
    if (state_d != state_q || (state_q == ST_CLOSED && expire)) begin
      cnt_d = 8'h00;
    end else if (tick) begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  // State, counter and registered outputs
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_WAIT_CORE;
      cnt_q <= 8'h00;
      reset_out_n_q <= 1'b0;
      early_q <= 1'b0;
      late_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      reset_out_n_q <= is_released(state_d);
      early_q <= fault_early;
      late_q <= fault_late;
    end
  end

  assign reset_out_n = reset_out_n_q;
  assign wd_fault_early = early_q;
  assign wd_fault_late = late_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  chk_delay_holds_low: assert property (state_q == ST_DELAY |-> !reset_out_n_q)
    else $error("reset released during power-up delay");
  chk_release_needs_io: assert property ($rose(reset_out_n_q) |-> $past(io_s) && $past(state_q) == ST_WAIT_IO)
    else $error("reset released without I/O supply check");
  chk_delay_length: assert property ($rose(state_q == ST_WAIT_IO) |-> $past(cnt_q) == POR_LAST && $past(tick))
    else $error("power-up delay not the configured tick count");
  chk_supply_fail_reset: assert property (any_fail && is_released(state_q) |=> !reset_out_n_q)
    else $error("supply failure did not pull reset low");
  chk_glitch_filter: assert property ($rose(sup_fail_q[SUP_CORE]) |-> $past(low_cnt_q[SUP_CORE]) == REACT_LAST)
    else $error("core supply failure declared before reaction time");
  chk_wd_off_quiet: assert property (wd_off_s |-> !fault_early && !fault_late)
    else $error("disabled watchdog raised a fault");
  chk_ignore_trigger: assert property (state_q == ST_IGNORE && trig_valid && !expire && !any_fail && !wd_off_s
    |=> state_q == ST_IGNORE)
    else $error("trigger acted during ignore window");
  chk_open_to_closed: assert property (state_q == ST_OPEN && trig_valid && !any_fail && !wd_off_s
    |=> state_q == ST_CLOSED && cnt_q == 8'h00)
    else $error("valid trigger did not start closed window");
  chk_pretrigger_reset: assert property (fault_early |=> !reset_out_n_q && wd_fault_early ##1 !wd_fault_early)
    else $error("premature trigger did not reset");
  chk_closed_expire: assert property (state_q == ST_CLOSED && expire && !trig_valid && !any_fail && !wd_off_s
    |=> state_q == ST_OPEN)
    else $error("closed window expiry did not reopen");
  chk_open_timeout: assert property (fault_late |=> !reset_out_n_q && state_q == ST_DELAY)
    else $error("missed trigger did not reset");
  chk_late_edge_ok: assert property (state_q == ST_CLOSED && expire && trig_valid && !any_fail && !wd_off_s
    |=> state_q == ST_CLOSED && reset_out_n_q)
    else $error("trigger ending at open window start was refused");

  cov_good_cycle: cover property (state_q == ST_OPEN && trig_valid ##1 state_q == ST_CLOSED);
  cov_pretrigger: cover property (fault_early);
  cov_timeout: cover property (fault_late);
  cov_wd_off: cover property (state_q == ST_WD_OFF && reset_out_n_q);
endmodule

// *** rww_tb_if.sv ***
`timescale 1ns/1ps
// Timebase and trigger sampler link between supervisor and sampler
interface rww_tb_if;
  logic slow;
  logic trig_lvl;
  logic tick;
  logic trig_valid;
  modport src (input slow, input trig_lvl, output tick, output trig_valid);
  modport snk (output slow, output trig_lvl, input tick, input trig_valid);
endinterface

// *** rww_timebase.sv ***
`timescale 1ns/1ps
module rww_timebase
  import rww_pkg::*;
#(
  parameter int SAMPLE_CYC = SAMPLE_CYC_DEF
) (
  input wire logic core_clk, // Core clock
  input wire logic reset, // Async reset, active high
  rww_tb_if.src tb // Tick and trigger detect
);
  logic [15:0] pre_q;
  logic [3:0] hist_q;
  logic tick_q;
  logic valid_q;

  if (SAMPLE_CYC < 2 || SAMPLE_CYC * SLOW_FACTOR > 65536) begin : g_bad_cyc
    $error("rww_timebase: SAMPLE_CYC out of range");
  end

  // Prescaler length, one common tick for the delay, the windows and the trigger samples
  wire [15:0] period_m1 = tb.slow ? 16'(SAMPLE_CYC * SLOW_FACTOR - 1) : 16'(SAMPLE_CYC - 1);
  wire wrap = pre_q >= period_m1;
  wire [3:0] hist_next = {hist_q[2:0], tb.trig_lvl};
  wire match = hist_next == TRIG_PATTERN;

  // Divider, trigger sampling and falling edge decode
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pre_q <= 16'h0000;
      hist_q <= 4'h0;
      tick_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      pre_q <= wrap ? 16'h0000 : pre_q + 16'h0001;
      tick_q <= wrap;
      if (wrap) begin
        hist_q <= hist_next;
      end
      valid_q <= wrap && match;
    end
  end

  assign tb.tick = tick_q;
  assign tb.trig_valid = valid_q;

  chk_trig_pattern: assert property (@(posedge core_clk) disable iff (reset)
    tb.trig_valid |-> tb.tick && hist_q == TRIG_PATTERN)
    else $error("trigger flagged without high-high-low-low samples");
  chk_tick_single: assert property (@(posedge core_clk) disable iff (reset)
    tb.tick |=> !tb.tick)
    else $error("sample tick lasted more than one cycle");
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import rww_pkg::*;
  localparam int SC = 4;
  localparam int PT = 4;
  localparam int WT = 8;
  localparam int RC = 3;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic core_supply_good = 1'b0;
  logic io_supply_good = 1'b0;
  logic strap_low = 1'b0;
  logic strap_at_core = 1'b0;
  logic fire = 1'b0;
  logic trigger_in;
  logic reset_out_n;
  logic wd_fault_early;
  logic wd_fault_late;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_early = 0;
  int n_late = 0;
  int cyc = 0;
  int t_mark = 0;

  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  rww_supervisor #(.SAMPLE_CYC(SC), .POR_TICKS(PT), .WIN_TICKS(WT), .REACT_CYC(RC)) rww_supervisor_i (
    .core_clk(core_clk), .reset(reset), .core_supply_good(core_supply_good),
    .io_supply_good(io_supply_good), .trigger_in(trigger_in), .strap_low(strap_low),
    .strap_at_core(strap_at_core), .reset_out_n(reset_out_n), .wd_fault_early(wd_fault_early),
    .wd_fault_late(wd_fault_late));

  rww_mcu_model rww_mcu_model_i (.core_clk(core_clk), .reset_out_n(reset_out_n), .fire(fire),
    .trigger_in(trigger_in));

  // Cycle count and fault pulse tally
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (wd_fault_early === 1'b1) n_early <= n_early + 1;
    if (wd_fault_late === 1'b1) n_late <= n_late + 1;
  end

  task automatic summarize();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_range(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h lo=%h hi=%h", $time, got, lo, hi);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Bounded wait for the reset output to reach a level
  task automatic wait_out(input logic v, input int lim);
    int n;
    n = 0;
    while (reset_out_n !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  task automatic pulse_trigger();
    @(posedge core_clk);
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
  endtask

  // Reset with core supply good, chosen I/O supply and strap, then time the release of the reset output when the I/O supply is good
  task automatic power_up(input logic io, input logic slow, input logic off);
    int k;
    k = slow ? 4 : 1;
    @(posedge core_clk);
    reset <= 1'b1;
    core_supply_good <= 1'b1;
    io_supply_good <= io;
    strap_at_core <= slow;
    strap_low <= off;
    cycles(5);
    reset <= 1'b0;
    n_early = 0;
    n_late = 0;
    t_mark = cyc;
    if (io) begin
      wait_out(1'b1, PT * SC * k + 40);
      check_range(cyc - t_mark, (PT - 1) * SC * k, PT * SC * k + 10);
      t_mark = cyc;
    end
  endtask

  task automatic t_io_late();
    power_up(1'b0, 1'b0, 1'b0);
    cycles(PT * SC * 3);
    check_val(reset_out_n, 1'b0);
    io_supply_good <= 1'b1;
    t_mark = cyc;
    wait_out(1'b1, 40);
    check_range(cyc - t_mark, 1, 8);
  endtask

  task automatic t_glitch();
    power_up(1'b1, 1'b0, 1'b0);
    core_supply_good <= 1'b0;
    cycles(RC - 1);
    core_supply_good <= 1'b1;
    cycles(12);
    check_val(reset_out_n, 1'b1);
    io_supply_good <= 1'b0;
    t_mark = cyc;
    wait_out(1'b0, 40);
    check_range(cyc - t_mark, RC + 1, RC + 6);
  endtask

  // A trigger inside the ignore window must not count, so the open window runs out
  task automatic t_ignore_late(input logic slow);
    int k;
    k = slow ? 4 : 1;
    power_up(1'b1, slow, 1'b0);
    pulse_trigger();
    wait_out(1'b0, 2 * WT * SC * k + 40);
    check_range(cyc - t_mark, (2 * WT - 3) * SC * k, 2 * WT * SC * k + 8);
    // Let the fault pulse reach the tally before reading it
    cycles(2);
    check_val(n_early, 32'h0);
    check_val(n_late, 32'h1);
  endtask

  task automatic t_service();
    power_up(1'b1, 1'b0, 1'b0);
    cycles(WT * SC - 2);
    repeat (3) begin
      pulse_trigger();
      cycles(50);
    end
    check_val(reset_out_n, 1'b1);
    check_val(n_early + n_late, 32'h0);
    wait_out(1'b0, 120);
    cycles(2);
    check_val(n_late, 32'h1);
  endtask

  // Second trigger timed so its last low sample lands on the closed window expiry tick
  task automatic t_late_edge();
    power_up(1'b1, 1'b0, 1'b0);
    cycles(WT * SC - 2);
    pulse_trigger();
    cycles(29);
    pulse_trigger();
    cycles(20);
    check_val(reset_out_n, 1'b1);
    check_val(n_early, 32'h0);
    check_val(n_late, 32'h0);
  endtask

  task automatic t_early();
    power_up(1'b1, 1'b0, 1'b0);
    cycles(WT * SC - 2);
    pulse_trigger();
    cycles(19);
    pulse_trigger();
    wait_out(1'b0, 80);
    cycles(2);
    check_val(n_early, 32'h1);
    check_val(n_late, 32'h0);
    t_mark = cyc;
    wait_out(1'b1, PT * SC + 40);
    check_range(cyc - t_mark, (PT - 1) * SC, PT * SC + 10);
  endtask

  task automatic t_wd_off();
    power_up(1'b1, 1'b0, 1'b1);
    cycles(4 * WT * SC);
    check_val(reset_out_n, 1'b1);
    check_val(n_late, 32'h0);
  endtask

  // Main sequence
  initial begin
    t_io_late();
    t_glitch();
    t_ignore_late(1'b0);
    t_service();
    t_early();
    t_late_edge();
    t_wd_off();
    t_ignore_late(1'b1);
    summarize();
  end

  // Watchdog against a hang, well beyond the fewer than 1500 cycles expected
  initial begin
    #(20000 * 50);
    n_mismatch++;
    summarize();
  end
endmodule
